// >>> rtl/pct_regs.svh
// Constants for the pipelined core timing block
`ifndef PCT_REGS_SVH
`define PCT_REGS_SVH
`define PCT_FRAME_BITS 5'h1C
`define PCT_FRAME_LAST 5'h1B
`define PCT_F_CMD_HI 27
`define PCT_F_CMD_LO 24
`define PCT_F_ADR_HI 23
`define PCT_F_ADR_LO 8
`define PCT_F_DAT_HI 7
`define PCT_F_DAT_LO 0
`define PCT_RESET_PC 16'h0000
`define PCT_OP_NOP 8'h00
`define PCT_OP_SPARE 8'hA5
`define PCT_SFR_BIT 7
`endif

// >>> rtl/pct_pkg.sv
// Types for the pipelined core timing block
`default_nettype none
package pct_pkg;
   typedef enum logic [1:0] {
      PCT_RUN = 2'h0,
      PCT_STEP = 2'h1,
      PCT_HALT = 2'h3
   } pct_mode_t;
   typedef enum logic [3:0] {
      PCT_C_HALT = 4'h1,
      PCT_C_RUN = 4'h2,
      PCT_C_STEP = 4'h3,
      PCT_C_BP = 4'h4,
      PCT_C_WP = 4'h5,
      PCT_C_CLR = 4'h6,
      PCT_C_RAMWR = 4'h7,
      PCT_C_RAMRD = 4'h8,
      PCT_C_PCRD = 4'h9,
      PCT_C_CODEWR = 4'hA
   } pct_cmd_t;
   typedef enum logic [2:0] {
      PCT_T_SEQ = 3'h0,
      PCT_T_REL = 3'h1,
      PCT_T_A11 = 3'h2,
      PCT_T_A16 = 3'h3,
      PCT_T_EXT = 3'h4
   } pct_tgt_t;
endpackage
`default_nettype wire

// >>> rtl/pct_core.sv
// Instruction sequencer, internal RAM and debug port of the pipelined core
// Function
// RULE_01 - Opcodes decode with standard 8-bit set encodings and lengths
// RULE_02 - Timing counts plain clock cycles, no machine cycles
// RULE_03 - Most instructions take as many cycles as they have bytes
// RULE_04 - Conditional branch not taken ends one cycle sooner than taken
// RULE_05 - No instruction takes more than eight cycles
// RULE_06 - Roughly seventy percent of instructions finish in one or two cycles
// RULE_07 - 109 instructions split across the documented cycle classes
// RULE_08 - 256 bytes internal RAM and separate 128-byte SPECIAL_FUNCTION_REGISTER_SPACE space
// RULE_09 - One instruction per clock in the best case
// RULE_10 - Serial port lets a host program flash and drive debug
// RULE_11 - Hardware breakpoint and data watch point stop execution
// RULE_12 - Host can run, halt, single-step and access registers and memory
// RULE_13 - Debug uses no application-visible resources
// RULE_14 - Code reads and external-data writes reach program flash
// RULE_15 - Spare opcode behaves exactly as no-operation
// RULE_16 - Relative targets add signed offset to next instruction address
// RULE_17 - 11-bit targets stay in the 2K page of the next instruction
`timescale 1ns/10ps
`default_nettype none
`include "pct_regs.svh"
module pct_core #(
   parameter int RAM_BYTES = 256
) (
   // Clock, reset, enable
   input wire logic ref_clk,
   input wire logic arst_n,
   input wire logic clk_en,
   // Program memory
   output logic [15:0] code_addr,
   input wire logic [7:0] code_data,
   // Execution datapath
   output logic instr_start,
   output logic instr_done,
   output logic [7:0] op_code,
   output logic [7:0] operand1,
   output logic [7:0] operand2,
   input wire logic branch_taken,
   input wire logic [15:0] ext_target,
   input wire logic flash_wr_en,
   output logic code_rd_req,
   output logic flash_wr_req,
   // Internal RAM and SPECIAL_FUNCTION_REGISTER_SPACE split
   input wire logic ram_we,
   input wire logic ram_direct,
   input wire logic [7:0] ram_addr,
   input wire logic [7:0] ram_wdata,
   output logic [7:0] ram_rdata,
   output logic sfr_sel,
   input wire logic data_acc_valid,
   input wire logic [7:0] data_acc_addr,
   // Debug and programming port
   input wire logic dbg_sel,
   input wire logic dbg_sck,
   input wire logic dbg_sdi,
   output logic dbg_sdo,
   output logic dbg_sdo_oe,
   output logic halted,
   output logic code_wr_req,
   output logic [15:0] code_wr_addr,
   output logic [7:0] code_wr_data
);
   import pct_pkg::*;

   if (RAM_BYTES != 256) begin : g_chk
      $error("internal RAM must be 256 bytes");
   end

   // ------------------------------------------------------------
   // Decode functions
   // ------------------------------------------------------------
   function automatic logic [1:0] pct_len(input logic [7:0] op); // [RULE_01]
      logic [3:0] hi;
      hi = op[7:4];
      unique case (op[3:0])
         4'h0: pct_len = (op inside {8'h10, 8'h20, 8'h30, 8'h90}) ? 2'h3 :
                         (op inside {8'h00, 8'hE0, 8'hF0}) ? 2'h1 : 2'h2;
         4'h1: pct_len = 2'h2;
         4'h2: pct_len = (op inside {8'h02, 8'h12}) ? 2'h3 :
                         (op inside {8'h22, 8'h32, 8'hE2, 8'hF2}) ? 2'h1 : 2'h2;
         4'h3: pct_len = (op inside {8'h43, 8'h53, 8'h63}) ? 2'h3 : 2'h1;
         4'h4: pct_len = (op == 8'hB4) ? 2'h3 :
                         (hi inside {4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h9}) ? 2'h2 : 2'h1;
         4'h5: pct_len = (op inside {8'h75, 8'h85, 8'hB5, 8'hD5}) ? 2'h3 :
                         (op == `PCT_OP_SPARE) ? 2'h1 : 2'h2; // [RULE_15]
         4'h6, 4'h7: pct_len = (hi == 4'hB) ? 2'h3 :
                               (hi inside {4'h7, 4'h8, 4'hA}) ? 2'h2 : 2'h1;
         default: pct_len = (hi == 4'hB) ? 2'h3 :
                            (hi inside {4'h7, 4'h8, 4'hA, 4'hD}) ? 2'h2 : 2'h1;
      endcase
   endfunction

   function automatic logic pct_cond(input logic [7:0] op);
      pct_cond = op inside {8'h10, 8'h20, 8'h30, 8'h40, 8'h50, 8'h60, 8'h70,
                            8'hD5, [8'hB4:8'hBF], [8'hD8:8'hDF]};
   endfunction

   // Cycles with branch not taken; a taken branch adds one
   function automatic logic [3:0] pct_base(input logic [7:0] op);
      logic [1:0] ln;
      ln = pct_len(op);
      if (op inside {8'h83, 8'h93, 8'hE0, 8'hE2, 8'hE3, 8'hF0, 8'hF2, 8'hF3})
         pct_base = 4'h3;
      else if (op == 8'h84)
         pct_base = 4'h8; // [RULE_05]
      else if (op inside {8'h22, 8'h32})
         pct_base = 4'h5;
      else if (op inside {8'hA4, 8'h02, 8'h12, 8'hB6, 8'hB7})
         pct_base = 4'h4;
      else if (op[3:0] == 4'h1 || op inside {8'h80, 8'h73})
         pct_base = 4'h3;
      else if (ln == 2'h1 && op[3:1] == 3'h3)
         pct_base = 4'h2;
      else
         pct_base = {2'h0, ln}; // [RULE_03] [RULE_06] [RULE_07]
   endfunction

   function automatic pct_tgt_t pct_tgt(input logic [7:0] op);
      if (pct_cond(op) || op == 8'h80)
         pct_tgt = PCT_T_REL;
      else if (op[3:0] == 4'h1)
         pct_tgt = PCT_T_A11;
      else if (op inside {8'h02, 8'h12})
         pct_tgt = PCT_T_A16;
      else if (op inside {8'h22, 8'h32, 8'h73})
         pct_tgt = PCT_T_EXT;
      else
         pct_tgt = PCT_T_SEQ;
   endfunction

   // ------------------------------------------------------------
   // Sequencer
   // ------------------------------------------------------------
   pct_mode_t mode_r, mode_nxt;
   logic [15:0] fa_r, fa_nxt, pc_r, pc_nxt, bp_r, bp_nxt;
   logic [2:0] cyc_r, cyc_nxt;
   logic [7:0] op_r, op_nxt, o1_r, o1_nxt, o2_r, o2_nxt, wp_r, wp_nxt;
   logic bp_en_r, bp_en_nxt, wp_en_r, wp_en_nxt, wpend_r, wpend_nxt, skip_r, skip_nxt;
   logic [7:0] cur_op, rel;
   logic [1:0] len;
   logic [3:0] base;
   logic [15:0] spc, seq;
   logic active, go, bp_hit, ext;
   pct_tgt_t tg;
   // Debug command decode, filled in below
   logic exec;
   pct_cmd_t cmd;
   logic [15:0] dadr;
   logic [7:0] ddat;

   always_comb begin
      cur_op = (cyc_r == 3'h0) ? code_data : op_r;
      len = pct_len(cur_op);
      base = pct_base(cur_op);
      tg = pct_tgt(cur_op);
      spc = (cyc_r == 3'h0) ? fa_r : pc_r;
      seq = spc + {14'h0000, len};
      rel = (len == 2'h2) ? o1_r : o2_r;
      bp_hit = bp_en_r && fa_r == bp_r && !skip_r; // [RULE_11]
      go = mode_r != PCT_HALT && !bp_hit;
      instr_start = cyc_r == 3'h0 && go;
      active = instr_start || cyc_r != 3'h0;
      ext = active && pct_cond(cur_op) && branch_taken &&
            {1'b0, cyc_r} == base - 4'h1; // [RULE_04]
      instr_done = active && !ext && ({1'b0, cyc_r} == base - 4'h1 || {1'b0, cyc_r} == base);
      mode_nxt = mode_r;
      fa_nxt = fa_r;
      pc_nxt = instr_start ? fa_r : pc_r;
      op_nxt = op_r;
      o1_nxt = o1_r;
      o2_nxt = o2_r;
      skip_nxt = instr_start ? 1'b0 : skip_r;
      wpend_nxt = wpend_r || (wp_en_r && data_acc_valid && data_acc_addr == wp_r); // [RULE_11]
      bp_nxt = bp_r;
      wp_nxt = wp_r;
      bp_en_nxt = bp_en_r;
      wp_en_nxt = wp_en_r;
      cyc_nxt = (active && !instr_done) ? cyc_r + 3'h1 : 3'h0; // [RULE_02]
      if (active && {1'b0, cyc_r} < {2'h0, len}) begin
         fa_nxt = fa_r + 16'h0001;
         unique case (cyc_r)
            3'h0: op_nxt = code_data;
            3'h1: o1_nxt = code_data;
            default: o2_nxt = code_data;
         endcase
      end
      if (instr_done) begin
         fa_nxt = seq; // [RULE_09] [RULE_15]
         if ({1'b0, cyc_r} == base || tg == PCT_T_A11 || tg == PCT_T_A16 || tg == PCT_T_EXT ||
             cur_op == 8'h80) begin
            unique case (tg)
               PCT_T_REL: fa_nxt = seq + {{8{rel[7]}}, rel}; // [RULE_16]
               PCT_T_A11: fa_nxt = {seq[15:11], cur_op[7:5], o1_r}; // [RULE_17]
               PCT_T_A16: fa_nxt = {o1_r, o2_r};
               PCT_T_EXT: fa_nxt = ext_target;
               default: fa_nxt = seq;
            endcase
         end
         if (mode_r == PCT_STEP || wpend_nxt) begin
            mode_nxt = PCT_HALT; // [RULE_12]
            wpend_nxt = 1'b0;
         end
      end
      if (cyc_r == 3'h0 && bp_hit && mode_r != PCT_HALT)
         mode_nxt = PCT_HALT; // [RULE_11]
      if (exec) begin
         unique case (cmd)
            PCT_C_HALT: mode_nxt = PCT_HALT; // [RULE_12]
            PCT_C_RUN: begin
               mode_nxt = PCT_RUN;
               skip_nxt = 1'b1;
            end
            PCT_C_STEP: if (mode_r == PCT_HALT) begin
               mode_nxt = PCT_STEP;
               skip_nxt = 1'b1;
            end
            PCT_C_BP: begin
               bp_nxt = dadr;
               bp_en_nxt = 1'b1;
            end
            PCT_C_WP: begin
               wp_nxt = dadr[7:0];
               wp_en_nxt = 1'b1;
            end
            PCT_C_CLR: begin
               bp_en_nxt = 1'b0;
               wp_en_nxt = 1'b0;
            end
            default: ;
         endcase
      end
   end

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         mode_r <= PCT_RUN;
         fa_r <= `PCT_RESET_PC;
         pc_r <= `PCT_RESET_PC;
         cyc_r <= 3'h0;
         op_r <= `PCT_OP_NOP;
         o1_r <= 8'h00;
         o2_r <= 8'h00;
         bp_r <= 16'h0000;
         wp_r <= 8'h00;
         bp_en_r <= 1'b0;
         wp_en_r <= 1'b0;
         wpend_r <= 1'b0;
         skip_r <= 1'b0;
      end else if (clk_en) begin
         mode_r <= mode_nxt;
         fa_r <= fa_nxt;
         pc_r <= pc_nxt;
         cyc_r <= cyc_nxt;
         op_r <= op_nxt;
         o1_r <= o1_nxt;
         o2_r <= o2_nxt;
         bp_r <= bp_nxt;
         wp_r <= wp_nxt;
         bp_en_r <= bp_en_nxt;
         wp_en_r <= wp_en_nxt;
         wpend_r <= wpend_nxt;
         skip_r <= skip_nxt;
      end
   end

   assign code_addr = fa_r;
   assign op_code = op_r;
   assign operand1 = o1_r;
   assign operand2 = o2_r;
   assign halted = mode_r == PCT_HALT;
   assign code_rd_req = instr_done && cur_op inside {8'h83, 8'h93}; // [RULE_14]
   assign flash_wr_req = instr_done && flash_wr_en &&
                         cur_op inside {8'hF0, 8'hF2, 8'hF3}; // [RULE_14]

   // ------------------------------------------------------------
   // Internal RAM
   // ------------------------------------------------------------
   // Upper direct addresses belong to the SPECIAL_FUNCTION_REGISTER_SPACE space; writes to them skip this array, reads still return it
   logic [7:0] iram [RAM_BYTES];
   logic [7:0] rd_r;
   logic dbg_wr;
   assign sfr_sel = ram_direct && ram_addr[`PCT_SFR_BIT]; // [RULE_08]
   assign dbg_wr = exec && cmd == PCT_C_RAMWR && halted && cyc_r == 3'h0;

   always_ff @(posedge ref_clk) begin
      if (clk_en) begin
         rd_r <= iram[ram_addr];
         if (ram_we && !sfr_sel)
            iram[ram_addr] <= ram_wdata; // [RULE_08]
         else if (dbg_wr)
            iram[dadr[7:0]] <= ddat; // [RULE_12]
      end
   end
   assign ram_rdata = rd_r;

   // ------------------------------------------------------------
   // Debug serial port
   // ------------------------------------------------------------
   // Serial port state lives here, breakpoint, watch point and mode state in the sequencer; the program sees none of it
   logic sck_r, sck_nxt, oe_r, oe_nxt, cw_r, cw_nxt, rise;
   logic [4:0] cnt_r, cnt_nxt;
   logic [27:0] sh_r, sh_nxt, word;
   logic [15:0] rsp_r, rsp_nxt, cwa_r, cwa_nxt;
   logic [7:0] cwd_r, cwd_nxt;

   always_comb begin
      rise = dbg_sel && dbg_sck && !sck_r;
      word = {sh_r[26:0], dbg_sdi};
      exec = rise && cnt_r == `PCT_FRAME_LAST; // [RULE_10]
      cmd = pct_cmd_t'(word[`PCT_F_CMD_HI:`PCT_F_CMD_LO]);
      dadr = word[`PCT_F_ADR_HI:`PCT_F_ADR_LO];
      ddat = word[`PCT_F_DAT_HI:`PCT_F_DAT_LO];
      sck_nxt = dbg_sck;
      oe_nxt = dbg_sel;
      sh_nxt = rise ? word : sh_r;
      cnt_nxt = !dbg_sel ? 5'h00 : exec ? 5'h00 : rise ? cnt_r + 5'h01 : cnt_r;
      rsp_nxt = rise ? {rsp_r[14:0], 1'b0} : rsp_r;
      cw_nxt = 1'b0;
      cwa_nxt = cwa_r;
      cwd_nxt = cwd_r;
      if (exec) begin
         if (cmd == PCT_C_RAMRD)
            rsp_nxt = {8'h00, iram[dadr[7:0]]}; // [RULE_12] [RULE_13]
         else if (cmd == PCT_C_PCRD)
            rsp_nxt = fa_r;
         else if (cmd == PCT_C_CODEWR && halted) begin
            cw_nxt = 1'b1; // [RULE_10]
            cwa_nxt = dadr;
            cwd_nxt = ddat;
         end
      end
   end

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         sck_r <= 1'b0;
         oe_r <= 1'b0;
         cnt_r <= 5'h00;
         sh_r <= 28'h0000000;
         rsp_r <= 16'h0000;
         cw_r <= 1'b0;
         cwa_r <= 16'h0000;
         cwd_r <= 8'h00;
      end else if (clk_en) begin
         sck_r <= sck_nxt;
         oe_r <= oe_nxt;
         cnt_r <= cnt_nxt;
         sh_r <= sh_nxt;
         rsp_r <= rsp_nxt;
         cw_r <= cw_nxt;
         cwa_r <= cwa_nxt;
         cwd_r <= cwd_nxt;
      end
   end
   assign dbg_sdo = rsp_r[15];
   assign dbg_sdo_oe = oe_r;
   assign code_wr_req = cw_r;
   assign code_wr_addr = cwa_r;
   assign code_wr_data = cwd_r;

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge ref_clk iff clk_en); endclocking
   default disable iff (!arst_n);
   logic [15:0] nxt_pc2;
   assign nxt_pc2 = pc_r + 16'h0002;
   sequence s_sjmp;
      instr_start && code_data == 8'h80 ##2 instr_done;
   endsequence
   // Any absolute jump, whatever its page bits
   sequence s_ajmp;
      instr_start && code_data[4:0] == 5'h01 ##2 instr_done;
   endsequence

   a_one_cycle_op: assert property (instr_start && code_data == 8'h04 |-> // [RULE_09]
         instr_done ##1 code_addr == $past(code_addr) + 16'h0001)
      else $error("one-byte op not single cycle");
   a_len_two_op: assert property (instr_start && code_data == 8'h24 |-> // [RULE_03]
         !instr_done ##1 instr_done)
      else $error("two-byte op not two cycles");
   a_jc_not_taken: assert property (instr_start && code_data == 8'h40 // [RULE_04]
         ##1 !branch_taken |-> instr_done)
      else $error("untaken branch too long");
   a_jc_taken: assert property (instr_start && code_data == 8'h40 // [RULE_04]
         ##1 branch_taken |-> !instr_done ##1 instr_done)
      else $error("taken branch wrong length");
   a_mul_four: assert property (instr_start && code_data == 8'hA4 |-> // [RULE_07]
         !instr_done [*3] ##1 instr_done)
      else $error("multiply not four cycles");
   a_div_eight: assert property (instr_start && code_data == 8'h84 |-> // [RULE_05]
         ##7 instr_done)
      else $error("divide not eight cycles");
   a_spare_nop: assert property (instr_start && code_data == `PCT_OP_SPARE |-> // [RULE_15]
         instr_done ##1 code_addr == $past(code_addr) + 16'h0001)
      else $error("spare opcode not a no-op");
   a_rel_target: assert property (s_sjmp |=> // [RULE_16]
         code_addr == nxt_pc2 + {{8{operand1[7]}}, operand1})
      else $error("relative target wrong");
   a_abs_page: assert property (s_ajmp |=> // [RULE_17]
         code_addr == {nxt_pc2[15:11], op_code[7:5], operand1})
      else $error("absolute target left page");
   a_bp_stop: assert property (cyc_r == 3'h0 && bp_hit && !halted |-> // [RULE_11]
         !instr_start ##1 halted)
      else $error("breakpoint did not stop");
   a_step_once: assert property (mode_r == PCT_STEP && instr_done && !exec |=> // [RULE_12]
         halted && !instr_start)
      else $error("step ran past one instruction");
   a_flash_write: assert property (flash_wr_req |-> // [RULE_14]
         instr_done && flash_wr_en && op_code inside {8'hF0, 8'hF2, 8'hF3})
      else $error("stray flash write");
endmodule
`default_nettype wire

// >>> bench/pct_code_mem.sv
// Program memory model that answers core fetches in the same cycle
`timescale 1ns/10ps
`default_nettype none
module pct_code_mem (
   // Fetch port
   input wire logic [15:0] code_addr,
   output logic [7:0] code_data
);
   // Unused space holds opcode zero, so fetches ahead of a jump stay harmless
   logic [7:0] mem [0:65535] = '{default: 8'h00};
   assign code_data = mem[code_addr];
endmodule
`default_nettype wire

// >>> bench/pipelined_cpu_core_timing_bench.sv
// Self-checking bench for the pipelined core timing block
`timescale 1ns/10ps
`default_nettype none
module pipelined_cpu_core_timing_bench;
   import pct_pkg::*;
   logic ref_clk, arst_n, branch_taken, flash_wr_en, ram_we, ram_direct;
   logic dbg_sel, dbg_sck, dbg_sdi;
   logic [7:0] ram_addr, ram_wdata, code_data, op_code, operand1, operand2, ram_rdata;
   logic [7:0] code_wr_data, wr_dat;
   logic [15:0] code_addr, code_wr_addr, wr_adr, rsp;
   logic instr_start, instr_done, code_rd_req, flash_wr_req, sfr_sel;
   logic dbg_sdo, dbg_sdo_oe, halted, code_wr_req;
   logic data_acc_valid;
   logic [7:0] data_acc_addr;
   int checks = 0, miscompares = 0, starts = 0, wr_seen = 0, s0;
   // Taken branch at 0x009 loops to itself once; the 0x913 jump loops forever
   localparam logic [7:0] PROG [14] = '{8'h00, 8'hA5, 8'h24, 8'h33, 8'h75, 8'h40, 8'h55,
      8'hA4, 8'h84, 8'h40, 8'hFE, 8'h02, 8'h07, 8'hFE};
   localparam int NCYC [14] = '{1, 1, 2, 3, 4, 8, 3, 2, 4, 3, 3, 3, 1, 3};
   localparam logic [15:0] NXT [14] = '{16'h0001, 16'h0002, 16'h0004, 16'h0007, 16'h0008,
      16'h0009, 16'h0009, 16'h000B, 16'h07FE, 16'h0910, 16'h0911, 16'h0912, 16'h0913,
      16'h0913};

   pct_code_mem i_mem (.code_addr(code_addr), .code_data(code_data));
   pct_core i_dut (.ref_clk(ref_clk), .arst_n(arst_n), .clk_en(1'b1), .code_addr(code_addr),
      .code_data(code_data), .instr_start(instr_start), .instr_done(instr_done),
      .op_code(op_code), .operand1(operand1), .operand2(operand2),
      .branch_taken(branch_taken), .ext_target(16'h0000), .flash_wr_en(flash_wr_en),
      .code_rd_req(code_rd_req), .flash_wr_req(flash_wr_req), .ram_we(ram_we),
      .ram_direct(ram_direct), .ram_addr(ram_addr), .ram_wdata(ram_wdata),
      .ram_rdata(ram_rdata), .sfr_sel(sfr_sel), .data_acc_valid(data_acc_valid),
      .data_acc_addr(data_acc_addr), .dbg_sel(dbg_sel), .dbg_sck(dbg_sck), .dbg_sdi(dbg_sdi),
      .dbg_sdo(dbg_sdo), .dbg_sdo_oe(dbg_sdo_oe), .halted(halted),
      .code_wr_req(code_wr_req), .code_wr_addr(code_wr_addr), .code_wr_data(code_wr_data));

   initial begin
      ref_clk = 1'b0;
      forever #2 ref_clk = ~ref_clk;
   end

   // Count instruction starts and capture code write pulses
   always @(posedge ref_clk) begin
      if (arst_n && instr_start === 1'b1) starts <= starts + 1;
      if (code_wr_req === 1'b1) begin
         wr_seen <= wr_seen + 1;
         wr_adr <= code_wr_addr;
         wr_dat <= code_wr_data;
      end
   end

   // ---------------------------------------------------------------
   // Shared tasks
   // ---------------------------------------------------------------
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic final_report;
      if (miscompares == 0 && checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   // Entered in an instruction's first cycle; leaves in the next one's first cycle
   task automatic exec(input int n, input logic [15:0] nxt, input logic rd, input logic wr,
         input logic bt);
      int c;
      c = 1;
      check("instr_start", instr_start, 1'b1);
      while (instr_done !== 1'b1 && c < 12) begin
         @(negedge ref_clk);
         c++;
      end
      check("cycles", 16'(c), 16'(n));
      check("code_rd_req", code_rd_req, rd);
      check("flash_wr_req", flash_wr_req, wr);
      @(posedge ref_clk) branch_taken <= bt;
      @(negedge ref_clk) check("next_pc", code_addr, nxt);
   endtask

   // Host side of the serial port: 28 bits MSB first, previous answer read back
   task automatic frame(input logic [3:0] cmd, input logic [15:0] adr, input logic [7:0] dat);
      logic [27:0] w;
      w = {cmd, adr, dat};
      rsp = '0;
      @(posedge ref_clk) dbg_sel <= 1'b1;
      for (int i = 27; i >= 0; i--) begin
         @(posedge ref_clk) begin
            dbg_sck <= 1'b0;
            dbg_sdi <= w[i];
         end
         @(negedge ref_clk);
         if (i > 11) rsp = {rsp[14:0], dbg_sdo};
         if (i == 27) check("sdo_oe", dbg_sdo_oe, 1'b1);
         @(posedge ref_clk) dbg_sck <= 1'b1;
      end
      @(posedge ref_clk) begin
         dbg_sck <= 1'b0;
         dbg_sel <= 1'b0;
      end
      repeat (4) @(posedge ref_clk);
   endtask

   task automatic halt_then_count(input int extra);
      for (int k = 0; k < 30 && halted !== 1'b1; k++) @(negedge ref_clk);
      repeat (12) @(negedge ref_clk);
      check("halted", halted, 1'b1);
      check("starts", 16'(starts - s0), 16'(extra));
   endtask

   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   task automatic run_program;
      for (int i = 0; i < 14; i++) begin
         exec(NCYC[i], NXT[i], i == 10, i == 11, i == 5);
         if (i == 3) begin
            check("op_code", op_code, 8'h75);
            check("operand1", operand1, 8'h40);
            check("operand2", operand2, 8'h55);
         end
      end
   endtask

   task automatic debug_session;
      frame(PCT_C_HALT, 16'h0000, 8'h00);
      s0 = starts;
      halt_then_count(0);
      frame(PCT_C_PCRD, 16'h0000, 8'h00);
      frame(PCT_C_RAMWR, 16'h0030, 8'h5A);
      check("pc_read", rsp, 16'h0913);
      frame(PCT_C_RAMRD, 16'h0030, 8'h00);
      s0 = starts;
      frame(PCT_C_STEP, 16'h0000, 8'h00);
      check("ram_read", rsp, 16'h005A);
      halt_then_count(1);
      frame(PCT_C_CODEWR, 16'h1234, 8'h3C);
      check("code_wr_count", 16'(wr_seen), 16'h0001);
      check("code_wr_addr", wr_adr, 16'h1234);
      check("code_wr_data", wr_dat, 8'h3C);
      frame(PCT_C_BP, 16'h0913, 8'h00);
      s0 = starts;
      frame(PCT_C_RUN, 16'h0000, 8'h00);
      halt_then_count(1);
   endtask

   // Cleared breakpoint lets the loop run; only the armed data address stops it
   task automatic watch_point;
      frame(PCT_C_CLR, 16'h0000, 8'h00);
      frame(PCT_C_WP, 16'h0044, 8'h00);
      frame(PCT_C_RUN, 16'h0000, 8'h00);
      repeat (12) @(negedge ref_clk);
      check("bp_cleared", halted, 1'b0);
      @(posedge ref_clk) begin
         data_acc_valid <= 1'b1;
         data_acc_addr <= 8'h45;
      end
      @(posedge ref_clk) data_acc_valid <= 1'b0;
      repeat (12) @(negedge ref_clk);
      check("wp_miss", halted, 1'b0);
      @(posedge ref_clk) begin
         data_acc_valid <= 1'b1;
         data_acc_addr <= 8'h44;
      end
      @(posedge ref_clk) data_acc_valid <= 1'b0;
      for (int k = 0; k < 12 && halted !== 1'b1; k++) @(negedge ref_clk);
      check("wp_stop", halted, 1'b1);
   endtask

   // Top address reached indirectly is RAM; the same address direct is special space
   task automatic ram_port;
      @(posedge ref_clk) begin
         ram_we <= 1'b1;
         ram_addr <= 8'hFF;
         ram_wdata <= 8'h11;
      end
      @(posedge ref_clk) begin
         ram_direct <= 1'b1;
         ram_wdata <= 8'h22;
      end
      @(negedge ref_clk) check("special_sel", sfr_sel, 1'b1);
      @(posedge ref_clk) begin
         ram_we <= 1'b0;
         ram_direct <= 1'b0;
      end
      repeat (2) @(negedge ref_clk);
      check("ram_top", ram_rdata, 8'h11);
      @(posedge ref_clk) ram_addr <= 8'h30;
      repeat (2) @(negedge ref_clk);
      check("ram_dbg", ram_rdata, 8'h5A);
   endtask

   initial begin
      arst_n <= 1'b0;
      branch_taken <= 1'b0;
      flash_wr_en <= 1'b1;
      {ram_we, ram_direct, dbg_sel, dbg_sck, dbg_sdi} <= 5'h00;
      ram_addr <= 8'h00;
      ram_wdata <= 8'h00;
      data_acc_valid <= 1'b0;
      data_acc_addr <= 8'h00;
      for (int i = 0; i < 14; i++) i_mem.mem[i] = PROG[i];
      i_mem.mem[16'h07FE] = 8'h21;
      i_mem.mem[16'h07FF] = 8'h10;
      i_mem.mem[16'h0910] = 8'h93;
      i_mem.mem[16'h0911] = 8'hF0;
      i_mem.mem[16'h0912] = 8'h04;
      i_mem.mem[16'h0913] = 8'h80;
      i_mem.mem[16'h0914] = 8'hFE;
      repeat (5) @(posedge ref_clk);
      arst_n <= 1'b1;
      @(negedge ref_clk);
      run_program();
      debug_session();
      watch_point();
      ram_port();
      final_report();
   end

   // Whole run is under a thousand cycles
   initial begin
      repeat (20000) @(posedge ref_clk);
      miscompares++;
      final_report();
   end
endmodule
`default_nettype wire
